// ### bench/backlight_ctrl_monitor.sv
/* checker for the backlight control bank, bound to the top ports.
   assumes a reset of at least three cycles. */
`timescale 1ns/100ps
`default_nettype none
`include "backlight_ctrl_defs.vh"
module backlight_ctrl_monitor (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic       key_press_i,
    input wire logic       amb_above_day_i,
    input wire logic       amb_above_office_i,
    input wire logic       overvoltage_condition_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       operating_o,
    input wire logic       backlight_on_o,
    input wire logic       dim_o,
    input wire logic       level_day_o,
    input wire logic       level_office_o,
    input wire logic       level_dark_o,
    input wire logic [3:0] law_sel_o,
    input wire logic       ovp_rampdown_o,
    input wire logic       fade_override_o
);
    logic       auto_q;
    logic       ovp_q;
    wire        ctl_wr = reg_wr_i && reg_addr_i == `BL_OFS_CONTROL;
    wire  [2:0] lvl    = {level_day_o, level_office_o, level_dark_o};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // copies of the auto and ramp-down enable bits; auto tells who owns the level field
    always @(posedge clk_i) begin
        if (rst_i)
            {auto_q, ovp_q} <= 2'b00;
        else if (ctl_wr)
            {auto_q, ovp_q} <= {reg_wdata_i[`BL_CTL_AUTO_BIT], reg_wdata_i[`BL_CTL_OVP_BIT]};
    end
    chk_level_dark: assert property (
        ctl_wr && !auto_q && reg_wdata_i[7:6] == `BRIGHTNESS_LEVEL_FIELD_DARK |-> ##2 lvl == 3'b001)
        else $error("level not dark after write");
    chk_level_resv: assert property (
        ctl_wr && !auto_q && reg_wdata_i[7:6] == `BRIGHTNESS_LEVEL_FIELD_RESERVED |-> ##2 lvl == 3'b100)
        else $error("reserved level not daylight");
    chk_law_follow: assert property (
        ctl_wr |-> ##2 law_sel_o == 4'h1 << $past(reg_wdata_i[5:4], 2))
        else $error("law select wrong");
    chk_fade_follow: assert property (
        ctl_wr |-> ##2 fade_override_o == $past(reg_wdata_i[1], 2))
        else $error("fade override wrong");
    chk_level_owner: assert property (
        $changed(lvl) |-> $past(ctl_wr, 2) || $past(auto_q, 2))
        else $error("level moved without owner");
    chk_auto_day: assert property (
        $past(auto_q, 2) && $past(amb_above_day_i, 2) |-> level_day_o)
        else $error("auto level not daylight");
    chk_ovp_gate: assert property (
        ovp_rampdown_o |-> $past(overvoltage_condition_i) && $past(ovp_q))
        else $error("ramp-down without overvoltage");
    chk_on_oper: assert property (
        backlight_on_o |-> operating_o)
        else $error("backlight on in standby");
    chk_dim_on: assert property (
        dim_o |-> backlight_on_o)
        else $error("dim while backlight off");
    cover property (ctl_wr && reg_wdata_i[`BL_CTL_AUTO_BIT]);
    cover property ($fell(backlight_on_o) && operating_o);
    cover property ($rose(dim_o));
    cover property (ovp_rampdown_o);
endmodule
`default_nettype wire

// ### bench/test_backlight_control_timers.sv
/* self-checking bench for the backlight control bank.
   assumes a short step count standing in for 5 s. */
`timescale 1ns/100ps
`default_nettype none
`include "backlight_ctrl_defs.vh"
module test_backlight_control_timers;
    localparam int STEP = 10;
    logic       clk_i, rst_i, reg_wr_i, reg_rd_i, key_press_i;
    logic       amb_above_day_i, amb_above_office_i, overvoltage_condition_i;
    logic [7:0] reg_addr_i, reg_wdata_i, d, c;
    wire  [7:0] reg_rdata_o;
    wire  [3:0] law_sel_o;
    wire        operating_o, backlight_on_o, dim_o, fade_override_o;
    wire        level_day_o, level_office_o, level_dark_o, ovp_rampdown_o;
    wire  [2:0] lvl = {level_day_o, level_office_o, level_dark_o};
    int         mismatches, tests_run, n;

    backlight_control_timers #(.STEP_CYCLES(31'd10)) dut (
        .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .key_press_i,
        .amb_above_day_i, .amb_above_office_i, .overvoltage_condition_i, .reg_rdata_o,
        .operating_o, .backlight_on_o, .dim_o, .level_day_o, .level_office_o,
        .level_dark_o, .law_sel_o, .ovp_rampdown_o, .fade_override_o);

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // strobes drop for a cycle so a following call never re-drives them at once
    task automatic wr(input logic [7:0] a, v);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        tick;
        reg_wr_i = 1'b0;
        tick;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick;
        reg_rd_i = 1'b0;
        tick;
        check("reg_rdata_o", exp, reg_rdata_o);
    endtask
    task automatic press;
        key_press_i = 1'b1;
        tick;
        key_press_i = 1'b0;
        tick;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [2:0] lvl_of(input logic [1:0] code);
        return code == 2'h1 ? 3'b010 : code == 2'h2 ? 3'b001 : 3'b100;
    endfunction
    // seconds over 5: 10..40 s in 5 s steps, then 50..120 s in 10 s steps
    function automatic int steps_of(input logic [3:0] code);
        return code <= 4'h7 ? code + 1 : 2 * code - 6;
    endfunction

    initial begin
        {rst_i, reg_wr_i, reg_rd_i, key_press_i} = 4'h8;
        {amb_above_day_i, amb_above_office_i, overvoltage_condition_i} = 3'h0;
        {reg_addr_i, reg_wdata_i, mismatches, tests_run} = '0;
        void'($urandom(98884));
        repeat (12) tick;
        rst_i = 1'b0;
        tick;
        for (int i = 0; i < 6; i++) rd(8'(i), 8'h00);
        check("level", 8'h04, {5'h0, lvl});
        check("law_sel_o", 8'h01, {4'h0, law_sel_o});
        wr(`BL_OFS_MODE, 8'hc0);
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            if (i < 4)
                d[7:4] = {i[1:0], i[1:0]};
            d[`BL_CTL_AUTO_BIT] = 1'b0;
            overvoltage_condition_i = 1'($urandom);
            wr(`BL_OFS_CONTROL, d);
            check("level", {5'h0, lvl_of(d[7:6])}, {5'h0, lvl});
            check("law_sel_o", 8'h01 << d[5:4], {4'h0, law_sel_o});
            check("fade_override_o", {7'h0, d[1]}, {7'h0, fade_override_o});
            check("ovp_rampdown_o", {7'h0, d[2] & overvoltage_condition_i},
                  {7'h0, ovp_rampdown_o});
            rd(`BL_OFS_CONTROL, d);
        end
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        rd(`BL_OFS_CONTROL, d);
        // level write under auto is dropped
        for (int i = 0; i < 4; i++) begin
            {amb_above_day_i, amb_above_office_i} = i[1:0];
            wr(`BL_OFS_CONTROL, 8'h88);
            check("level", {5'h0, i[1] ? 3'b100 : i[0] ? 3'b010 : 3'b001},
                  {5'h0, lvl});
        end
        rd(`BL_OFS_CONTROL, 8'h08);
        wr(`BL_OFS_CONTROL, 8'h40);
        {amb_above_day_i, amb_above_office_i} = 2'b00;
        repeat (4) tick;
        check("level", 8'h04, {5'h0, lvl});
        rd(`BL_OFS_CONTROL, 8'h00);
        check("backlight_on_o", 8'h01, {7'h0, backlight_on_o});
        check("dim_o", 8'h00, {7'h0, dim_o});
        for (int k = 0; k < 8; k++) begin
            c = k < 2 ? 8'h01 : k < 4 ? 8'h0f : k < 6 ? 8'h08 : 8'(1 + $urandom_range(14));
            wr(`BL_OFS_MODE, 8'h80);
            wr(`BL_OFS_TIMERS, k[0] ? c : c << 4);
            wr(`BL_OFS_MODE, 8'hc0);
            n = steps_of(c[3:0]) * STEP;
            repeat (n - 4) tick;
            check("backlight_on_o", 8'h01, {7'h0, backlight_on_o});
            check("dim_o", 8'h00, {7'h0, dim_o});
            for (int t = 0; t < 12; t++)
                if (k[0] ? dim_o !== 1'b1 : backlight_on_o !== 1'b0)
                    tick;
            check(k[0] ? "dim_o" : "backlight_on_o", {7'h0, k[0]},
                  {7'h0, k[0] ? dim_o : backlight_on_o});
            rd(`BL_OFS_MODE, k[0] ? 8'he0 : 8'h80);
        end
        wr(`BL_OFS_MODE, 8'h00);
        wr(`BL_OFS_TIMERS, 8'h00);
        wr(`BL_OFS_CONTROL, 8'h00);
        wr(`BL_OFS_MODE, 8'h80);
        press;
        check("backlight_on_o", 8'h00, {7'h0, backlight_on_o});
        wr(`BL_OFS_MODE, 8'h00);
        wr(`BL_OFS_CONTROL, 8'h01);
        wr(`BL_OFS_MODE, 8'h80);
        press;
        check("backlight_on_o", 8'h01, {7'h0, backlight_on_o});
        rd(`BL_OFS_MODE, 8'hc0);
        wr(`BL_OFS_MODE, 8'he0);
        repeat (100) tick;
        check("dim_o", 8'h01, {7'h0, dim_o});
        press;
        check("dim_o", 8'h00, {7'h0, dim_o});
        // key wake restarts the running timers
        wr(`BL_OFS_MODE, 8'h80);
        wr(`BL_OFS_TIMERS, 8'h10);
        press;
        repeat (15) tick;
        press;
        repeat (12) tick;
        check("backlight_on_o", 8'h01, {7'h0, backlight_on_o});
        repeat (12) tick;
        check("backlight_on_o", 8'h00, {7'h0, backlight_on_o});
        rst_i = 1'b1;
        repeat (2) tick;
        rst_i = 1'b0;
        tick;
        rd(`BL_OFS_MODE, 8'h00);
        check("backlight_on_o", 8'h00, {7'h0, backlight_on_o});
        wrap_up;
    end
endmodule

bind backlight_control_timers backlight_ctrl_monitor mon (
    .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .key_press_i,
    .amb_above_day_i, .amb_above_office_i, .overvoltage_condition_i, .reg_rdata_o,
    .operating_o, .backlight_on_o, .dim_o, .level_day_o, .level_office_o,
    .level_dark_o, .law_sel_o, .ovp_rampdown_o, .fade_override_o);
`default_nettype wire

// ### design/backlight_control_timers.v
/*
 * backlight control and off/dim timer register bank with its state logic.
 * assumes a host-side serial interface delivers one-cycle register strobes
 * synchronous to clk_i, and that comparator, key and overvoltage inputs
 * are already synchronous and debounced.
 */
`timescale 1ns/100ps
`default_nettype none
`include "backlight_ctrl_defs.vh"

// Functional notes
// R1: level field codes 00, 01, 10 pick daylight, office and dark.
// R2: law field codes 00..11 pick linear, square, cubic one, cubic two.
// R3: auto adjust clear leaves the level to software writes only.
// R4: auto adjust set lets comparators drive the level field.
// R5: ramp-down request follows overvoltage only while its enable is set; the code also requires backlight enable.
// R6: fade override output follows its control bit.
// R7: key wake set makes a key press in operating mode set backlight enable.
// R8: software sets key wake before leaving standby.
// R9: off timer code 0 disables, else 10 to 120 seconds.
// R10: dim timer uses the same duration codes as the off timer.
// R11: software programs both timers before enabling the backlight.
// R12: dim timer expiry sets dim enable; manual dim stays until cleared.
// R13: backlight enable bit turns the driver on, set by software or wake.
// R14: reserved level code 11 behaves as daylight.
// R15: off expiry clears enable; timers restart on enable or wake.
module backlight_control_timers #(
    parameter [30:0] STEP_CYCLES = `BL_STEP_CYCLES
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire       key_press_i,
    input  wire       amb_above_day_i,
    input  wire       amb_above_office_i,
    input  wire       overvoltage_condition_i,
    output reg  [7:0] reg_rdata_o,
    output reg        operating_o,
    output reg        backlight_on_o,
    output reg        dim_o,
    output reg        level_day_o,
    output reg        level_office_o,
    output reg        level_dark_o,
    output reg  [3:0] law_sel_o,
    output reg        ovp_rampdown_o,
    output reg        fade_override_o
);

    // register bits
    reg        standby_control_bit_q;
    reg        backlight_enable_bit_q;
    reg        dim_enable_q;
    reg  [1:0] brightness_level_field_q;
    reg  [1:0] fade_transfer_law_q;
    reg        auto_level_adjust_q;
    reg        overvoltage_rampdown_enable_q;
    reg        fade_override_q;
    reg        key_press_wake_q;
    reg  [3:0] off_timer_field_q;
    reg  [3:0] dim_timer_field_q;

    reg        standby_control_bit_d;
    reg        backlight_enable_bit_d;
    reg        dim_enable_d;
    reg  [1:0] brightness_level_field_d;

    // step prescaler and timer plumbing
    reg  [30:0] step_cnt_q;
    reg         step_tick_q;
    reg         enable_seen_q;
    wire        wr_mode;
    wire        wr_control;
    wire        wr_timers;
    wire        wake;
    wire        enable_rise;
    wire        timers_restart;
    wire        timers_run;
    wire        off_expired;
    wire        dim_expired;
    wire        lvl_day;
    wire        lvl_office;
    wire        lvl_dark;
    reg  [1:0]  ambient_level;
    reg  [3:0]  law_onehot;

    assign wr_mode    = reg_wr_i && (reg_addr_i == `BL_OFS_MODE);
    assign wr_control = reg_wr_i && (reg_addr_i == `BL_OFS_CONTROL);
    assign wr_timers  = reg_wr_i && (reg_addr_i == `BL_OFS_TIMERS);

    // R7: wake only in operating mode with key wake on
    assign wake = key_press_wake_q && key_press_i && standby_control_bit_q;

    assign enable_rise    = backlight_enable_bit_q && !enable_seen_q;
    // R15: restart on enable or key wake
    assign timers_restart = enable_rise || wake;
    assign timers_run     = backlight_enable_bit_q && standby_control_bit_q;

    // one shared prescaler; restarting it keeps the first step a full 5 s
    always @(posedge clk_i) begin
        if (rst_i) begin
            step_cnt_q    <= 31'h00000000;
            step_tick_q   <= 1'b0;
            enable_seen_q <= 1'b0;
        end else begin
            enable_seen_q <= backlight_enable_bit_q;
            step_tick_q   <= 1'b0;
            if (timers_restart || !timers_run) begin
                step_cnt_q <= 31'h00000000;
            end else if (step_cnt_q >= STEP_CYCLES - 31'h00000001) begin
                step_cnt_q  <= 31'h00000000;
                step_tick_q <= 1'b1;
            end else begin
                step_cnt_q <= step_cnt_q + 31'h00000001;
            end
        end
    end

    // R9: off timer
    duration_timer u_off_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (timers_run),
        .restart_i (timers_restart),
        .tick_i    (step_tick_q),
        .code_i    (off_timer_field_q),
        .expired_o (off_expired)
    );

    // R10: dim timer with the same codes
    duration_timer u_dim_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (timers_run),
        .restart_i (timers_restart),
        .tick_i    (step_tick_q),
        .code_i    (dim_timer_field_q),
        .expired_o (dim_expired)
    );

    // comparators pick the brightest level whose threshold is exceeded
    always @* begin
        if (amb_above_day_i) begin
            ambient_level = `BRIGHTNESS_LEVEL_FIELD_DAYLIGHT;
        end else if (amb_above_office_i) begin
            ambient_level = `BRIGHTNESS_LEVEL_FIELD_OFFICE;
        end else begin
            ambient_level = `BRIGHTNESS_LEVEL_FIELD_DARK;
        end
    end

    // mode and level bits: hardware events win over a same-cycle write
    always @* begin
        standby_control_bit_d    = standby_control_bit_q;
        backlight_enable_bit_d   = backlight_enable_bit_q;
        dim_enable_d             = dim_enable_q;
        brightness_level_field_d = brightness_level_field_q;
        if (wr_mode) begin
            standby_control_bit_d  = reg_wdata_i[`BL_MODE_OPER_BIT];
            // R13: software sets or clears enable
            backlight_enable_bit_d = reg_wdata_i[`BL_MODE_EN_BIT];
            // R12: manual dim persists until software, off expiry or a key wake clears it
            dim_enable_d           = reg_wdata_i[`BL_MODE_DIM_BIT];
        end
        // R15: off expiry turns the backlight off
        if (off_expired) begin
            backlight_enable_bit_d = 1'b0;
            dim_enable_d           = 1'b0;
        end
        // R12: dim expiry sets dim enable
        if (dim_expired) begin
            dim_enable_d = 1'b1;
        end
        // R7: key press wakes the backlight at full level
        if (wake) begin
            backlight_enable_bit_d = 1'b1;
            dim_enable_d           = 1'b0;
        end
        if (auto_level_adjust_q) begin
            // R4: state machine owns the level field
            brightness_level_field_d = ambient_level;
        end else if (wr_control) begin
            // R3: only software moves the level
            brightness_level_field_d = reg_wdata_i[`BL_CTL_LVL_HI:`BL_CTL_LVL_LO];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            standby_control_bit_q    <= 1'b0;
            backlight_enable_bit_q   <= 1'b0;
            dim_enable_q             <= 1'b0;
            brightness_level_field_q <= `BRIGHTNESS_LEVEL_FIELD_DAYLIGHT;
        end else begin
            standby_control_bit_q    <= standby_control_bit_d;
            backlight_enable_bit_q   <= backlight_enable_bit_d;
            dim_enable_q             <= dim_enable_d;
            brightness_level_field_q <= brightness_level_field_d;
        end
    end

    // R11: timers accept writes at any time; a new code applies from the next step tick
    always @(posedge clk_i) begin
        if (rst_i) begin
            fade_transfer_law_q           <= `FADE_TRANSFER_LAW_LINEAR;
            auto_level_adjust_q           <= 1'b0;
            overvoltage_rampdown_enable_q <= 1'b0;
            fade_override_q               <= 1'b0;
            key_press_wake_q              <= 1'b0;
            off_timer_field_q             <= `BL_TIMER_OFF_CODE;
            dim_timer_field_q             <= `BL_TIMER_OFF_CODE;
        end else begin
            if (wr_control) begin
                fade_transfer_law_q           <= reg_wdata_i[`BL_CTL_LAW_HI:`BL_CTL_LAW_LO];
                auto_level_adjust_q           <= reg_wdata_i[`BL_CTL_AUTO_BIT];
                overvoltage_rampdown_enable_q <= reg_wdata_i[`BL_CTL_OVP_BIT];
                fade_override_q               <= reg_wdata_i[`BL_CTL_FADE_OVERRIDE_BIT];
                // R8: set before standby exit so the first press counts
                key_press_wake_q              <= reg_wdata_i[`BL_CTL_KPW_BIT];
            end
            if (wr_timers) begin
                off_timer_field_q <= reg_wdata_i[`BL_TIM_OFF_HI:`BL_TIM_OFF_LO];
                dim_timer_field_q <= reg_wdata_i[`BL_TIM_DIM_HI:`BL_TIM_DIM_LO];
            end
        end
    end

    level_decode u_level_decode (
        .code_i   (brightness_level_field_q),
        .day_o    (lvl_day),
        .office_o (lvl_office),
        .dark_o   (lvl_dark)
    );

    // R2: transfer law one-hot select
    always @* begin
        case (fade_transfer_law_q)
            `FADE_TRANSFER_LAW_LINEAR: begin
                law_onehot = 4'h1;
            end
            `FADE_TRANSFER_LAW_SQUARE: begin
                law_onehot = 4'h2;
            end
            `FADE_TRANSFER_LAW_CUBIC1: begin
                law_onehot = 4'h4;
            end
            default: begin
                law_onehot = 4'h8;
            end
        endcase
    end

    // outputs are registered so the driver sees glitch-free controls
    always @(posedge clk_i) begin
        if (rst_i) begin
            operating_o     <= 1'b0;
            backlight_on_o  <= 1'b0;
            dim_o           <= 1'b0;
            level_day_o     <= 1'b1;
            level_office_o  <= 1'b0;
            level_dark_o    <= 1'b0;
            law_sel_o       <= 4'h1;
            ovp_rampdown_o  <= 1'b0;
            fade_override_o <= 1'b0;
        end else begin
            operating_o     <= standby_control_bit_q;
            // R13: driver on only with enable in operating mode
            backlight_on_o  <= backlight_enable_bit_q && standby_control_bit_q;
            dim_o           <= dim_enable_q && backlight_enable_bit_q && standby_control_bit_q;
            level_day_o     <= lvl_day;
            level_office_o  <= lvl_office;
            level_dark_o    <= lvl_dark;
            law_sel_o       <= law_onehot;
            // R5: ramp down only while enabled, backlight enable is set and overvoltage persists
            ovp_rampdown_o  <= overvoltage_rampdown_enable_q && overvoltage_condition_i
                               && backlight_enable_bit_q;
            // R6: fade override follows its bit
            fade_override_o <= fade_override_q;
        end
    end

    // read port; unused bits and unmapped offsets read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `BL_OFS_MODE: begin
                    reg_rdata_o <= {standby_control_bit_q, backlight_enable_bit_q,
                                    dim_enable_q, 5'h00};
                end
                `BL_OFS_CONTROL: begin
                    reg_rdata_o <= {brightness_level_field_q, fade_transfer_law_q,
                                    auto_level_adjust_q, overvoltage_rampdown_enable_q,
                                    fade_override_q, key_press_wake_q};
                end
                `BL_OFS_TIMERS: begin
                    reg_rdata_o <= {off_timer_field_q, dim_timer_field_q};
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### design/backlight_ctrl_defs.vh
/*
 * constants for the backlight control and timer register bank:
 * offsets, field positions, reset values, codes and timing counts.
 * assumes the includer runs on a 250 MHz clock.
 */
`ifndef BACKLIGHT_CTRL_DEFS_VH
`define BACKLIGHT_CTRL_DEFS_VH

`define BL_OFS_MODE        8'h00
`define BL_OFS_CONTROL     8'h02
`define BL_OFS_TIMERS      8'h03

`define BL_MODE_RESET      8'h00
`define BACKLIGHT_CONTROL_SETTINGS_RESET   8'h00
`define BL_TIMERS_RESET    8'h00

`define BL_MODE_OPER_BIT   7
`define BL_MODE_EN_BIT     6
`define BL_MODE_DIM_BIT    5

`define BL_CTL_LVL_HI      7
`define BL_CTL_LVL_LO      6
`define BL_CTL_LAW_HI      5
`define BL_CTL_LAW_LO      4
`define BL_CTL_AUTO_BIT    3
`define BL_CTL_OVP_BIT     2
`define BL_CTL_FADE_OVERRIDE_BIT    1
`define BL_CTL_KPW_BIT     0

`define BL_TIM_OFF_HI      7
`define BL_TIM_OFF_LO      4
`define BL_TIM_DIM_HI      3
`define BL_TIM_DIM_LO      0

`define BRIGHTNESS_LEVEL_FIELD_DAYLIGHT    2'h0
`define BRIGHTNESS_LEVEL_FIELD_OFFICE      2'h1
`define BRIGHTNESS_LEVEL_FIELD_DARK        2'h2
`define BRIGHTNESS_LEVEL_FIELD_RESERVED    2'h3

`define FADE_TRANSFER_LAW_LINEAR      2'h0
`define FADE_TRANSFER_LAW_SQUARE      2'h1
`define FADE_TRANSFER_LAW_CUBIC1      2'h2
`define FADE_TRANSFER_LAW_CUBIC2      2'h3

`define BL_TIMER_OFF_CODE  4'h0
`define BL_FINE_LAST_CODE  4'h7
`define BL_CLK_MHZ         250
`define BL_STEP_TIME_S     5
// one 5 s step at 250 MHz, sized to the prescaler width
`define BL_STEP_CYCLES     31'h4a817c80

`endif

// ### design/duration_timer.v
/*
 * inactivity timer counting 5 s steps for a 4-bit duration code.
 * assumes tick_i is a one-cycle pulse every step from the caller.
 */
`timescale 1ns/100ps
`default_nettype none
`include "backlight_ctrl_defs.vh"

module duration_timer (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       run_i,
    input  wire       restart_i,
    input  wire       tick_i,
    input  wire [3:0] code_i,
    output reg        expired_o
);

    reg  [4:0] steps_q;
    reg        done_q;
    reg  [4:0] target;

    // R9: 10..40 s by 5 s, 50..120 s by 10 s
    always @* begin
        if (code_i <= `BL_FINE_LAST_CODE) begin
            target = {1'b0, code_i} + 5'h01;
        end else begin
            target = {code_i, 1'b0} - 5'h06;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            steps_q   <= 5'h00;
            done_q    <= 1'b0;
            expired_o <= 1'b0;
        end else begin
            expired_o <= 1'b0;
            if (restart_i || !run_i) begin
                steps_q <= 5'h00;
                done_q  <= 1'b0;
            // R9: code zero never expires
            end else if (tick_i && !done_q && code_i != `BL_TIMER_OFF_CODE) begin
                if (steps_q + 5'h01 >= target) begin
                    expired_o <= 1'b1;
                    done_q    <= 1'b1;
                end
                steps_q <= steps_q + 5'h01;
            end
        end
    end

endmodule
`default_nettype wire

// ### design/level_decode.v
/*
 * decodes the brightness level field into one-hot operating levels.
 * assumes a purely combinational use; the caller registers the result.
 */
`timescale 1ns/100ps
`default_nettype none
`include "backlight_ctrl_defs.vh"

module level_decode (
    input  wire [1:0] code_i,
    output reg        day_o,
    output reg        office_o,
    output reg        dark_o
);

    always @* begin
        day_o    = 1'b0;
        office_o = 1'b0;
        dark_o   = 1'b0;
        // R1: level decode
        case (code_i)
            `BRIGHTNESS_LEVEL_FIELD_OFFICE: begin
                office_o = 1'b1;
            end
            `BRIGHTNESS_LEVEL_FIELD_DARK: begin
                dark_o = 1'b1;
            end
            // R14: reserved acts as daylight
            default: begin
                day_o = 1'b1;
            end
        endcase
    end

endmodule
`default_nettype wire
